// file: hdl/lcd_pkg.sv
// Shared constants, types and helpers of the segment LCD core.
package lcd_pkg;

    // ========================================
    // Geometry of the display memory and pointers.
    localparam int unsigned COLS      = 60;
    localparam int unsigned ROWS      = 4;
    localparam int unsigned PTR_W     = 7;
    localparam int unsigned SUB_W     = 3;
    localparam int unsigned BYTE_W    = 8;
    localparam logic [PTR_W-1:0] PTR_RST = 7'h00;
    localparam logic [SUB_W-1:0] SUB_RST = 3'h0;

    // ========================================
    // Timing: core clock, display clock and frame division.
    localparam int unsigned CORE_CLK_HZ      = 250_000_000;
    localparam int unsigned OSC_HZ           = 1536;
    localparam int unsigned OSC_TICK_CYC_DEF = CORE_CLK_HZ / OSC_HZ;
    localparam int unsigned OSC_CNT_W        = 18;
    localparam int unsigned FRAME_DIV        = 24;
    localparam int unsigned SLOT_W           = 5;

    // ========================================
    // Pointer steps and backplane counts per drive mode.
    localparam logic [7:0] STEP_STATIC = 8'h08;
    localparam logic [7:0] STEP_MUX2   = 8'h04;
    localparam logic [7:0] STEP_MUX3   = 8'h03;
    localparam logic [7:0] STEP_MUX4   = 8'h02;
    localparam logic [2:0] NROW_STATIC = 3'h1;
    localparam logic [2:0] NROW_MUX2   = 3'h2;
    localparam logic [2:0] NROW_MUX3   = 3'h3;
    localparam logic [2:0] NROW_MUX4   = 3'h4;

    typedef enum logic [1:0] {MODE_MUX4, MODE_STATIC, MODE_MUX2, MODE_MUX3} drive_mode_t;

    // Number of backplanes that a mode scans.
    function automatic logic [2:0] mode_rows(input drive_mode_t m);
        unique case (m)
            MODE_STATIC: mode_rows = NROW_STATIC;
            MODE_MUX2:   mode_rows = NROW_MUX2;
            MODE_MUX3:   mode_rows = NROW_MUX3;
            MODE_MUX4:   mode_rows = NROW_MUX4;
        endcase
    endfunction

    // Pointer advance after each display byte.
    function automatic logic [7:0] mode_step(input drive_mode_t m);
        unique case (m)
            MODE_STATIC: mode_step = STEP_STATIC;
            MODE_MUX2:   mode_step = STEP_MUX2;
            MODE_MUX3:   mode_step = STEP_MUX3;
            MODE_MUX4:   mode_step = STEP_MUX4;
        endcase
    endfunction

    // Display clock ticks spent on each backplane row.
    function automatic logic [SLOT_W-1:0] mode_slots(input drive_mode_t m);
        mode_slots = SLOT_W'(FRAME_DIV / int'(mode_rows(m)));
    endfunction

endpackage

// file: hdl/byte_stream_if.sv
// Valid and ready byte stream between the core and its input buffer.
`timescale 1ns/1ps
interface byte_stream_if #(parameter int unsigned W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: hdl/byte_skid_buf.sv
// Two-entry buffer that absorbs display bytes while the core stalls.
`timescale 1ns/1ps
module byte_skid_buf #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 2
) (
    // Clock, reset and freeze.
    input  wire logic   core_clk,
    input  wire logic   rst,
    input  wire logic   clk_en,
    // Filling and draining sides.
    byte_stream_if.snk  up,
    byte_stream_if.src  dn
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [W-1:0]  mem_nxt [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          rdy_r, rdy_nxt;
    logic          push, pop;

    assign up.ready = rdy_r;
    assign dn.valid = (cnt_r != '0);
    assign dn.data  = mem_r[rd_r];
    assign push     = up.valid && rdy_r;
    assign pop      = dn.valid && dn.ready;

    // Next pointers, fill level and ready, wrapping at the depth.
    always_comb begin
        mem_nxt = mem_r;
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = up.data;
            wr_nxt = (int'(wr_r) == DEPTH - 1) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (int'(rd_r) == DEPTH - 1) ? '0 : rd_r + 1'b1;
        end
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        rdy_nxt = (int'(cnt_nxt) < DEPTH);
    end

    // Registers only; the clock enable freezes the buffer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
        end else if (clk_en) begin
            mem_r <= mem_nxt;
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // A stalled head word stays put until it is taken.
    a_buf_head_hold: assert property (@(posedge core_clk) disable iff (rst)
        dn.valid && !dn.ready |=> dn.valid && $stable(dn.data))
        else $error("buffer head changed while stalled");

    // The fill level never passes the depth.
    a_buf_no_over: assert property (@(posedge core_clk) disable iff (rst)
        int'(cnt_r) <= DEPTH)
        else $error("buffer overfilled");
endmodule

// file: hdl/lcd_seg_core.sv
// Segment LCD core: clock select, frame scan, display memory and drive.
`timescale 1ns/1ps
// Summary of operation
// RULE1: OSC low: internal clock, driven out.
// RULE2: OSC high: clock pin is input.
// RULE3: Frame is selected clock divided by 24.
// RULE4: Shared sync pin aligns cascaded devices.
// RULE5: Display register holds row during phase.
// RULE6: Sixty segments from phase and register bit.
// RULE7: In 1:3, backplane 3 copies backplane 1.
// RULE8: In 1:2, 2 copies 0, 3 copies 1.
// RULE9: Static mode: all backplanes identical.
// RULE10: 60x4 memory; one is on, zero off.
// RULE11: Row n to backplane n, column k segment k.
// RULE12: Byte spread per mode over rows.
// RULE13: 1:3 leaves third column row 2 untouched.
// RULE14: Bytes stored from pointer-loaded column.
// RULE15: Pointer steps 8, 4, 3, 2 by mode.
// RULE16: Host reloads pointer after aborted transfer.
// RULE17: Store only when subaddress matches pins.
// RULE18: Mismatch drops byte, pointer still advances.
// RULE19: Subaddress loaded by command, bumps on overflow.
// RULE20: Host selects device then loads pointer.
// RULE21: Subaddress pins steady during access.
// RULE22: Clock must always be supplied.
// RULE23: Reset clears pointer and subaddress counter.
// RULE24: Sync restarts scan at last row.
// RULE25: Pointer overflows past column 59, wraps.
module lcd_seg_core #(
    parameter int unsigned OSC_TICK_CYC = lcd_pkg::OSC_TICK_CYC_DEF
) (
    // Clock, reset and freeze.
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Clock pin and its source select.
    input  wire logic        osc_sel,
    input  wire logic        clk_pin_in,
    output logic             clk_pin_out,
    output logic             clk_pin_oe,
    // Shared open-drain sync pin, low while asserted.
    input  wire logic        sync_n_in,
    output logic             sync_n_out,
    output logic             sync_n_oe,
    // Drive configuration and hardware subaddress.
    input  wire logic [1:0]  drive_mode,
    input  wire logic [2:0]  hw_subaddr_pins,
    // Decoded commands.
    input  wire logic        ptr_load_stb,
    input  wire logic [6:0]  ptr_load_val,
    input  wire logic        subaddr_load_stb,
    input  wire logic [2:0]  subaddr_load_val,
    // Display byte stream.
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic             byte_ready,
    // LCD drive.
    output logic [3:0]       backplane_drive_out,
    output logic [59:0]      segment_drive_out,
    output logic             frame_rate
);
    localparam int unsigned COLS = lcd_pkg::COLS;
    localparam int unsigned CW   = lcd_pkg::OSC_CNT_W;
    localparam int unsigned SW   = lcd_pkg::SLOT_W;
    localparam int unsigned PW   = lcd_pkg::PTR_W;
    localparam int FRAME_LAST    = lcd_pkg::FRAME_DIV - 1;

    lcd_pkg::drive_mode_t mode_c;
    logic [2:0]           nrows;
    logic [1:0]           last_row;
    logic [SW-1:0]        slots;
    logic [7:0]           step;

    assign mode_c   = lcd_pkg::drive_mode_t'(drive_mode);
    assign nrows    = lcd_pkg::mode_rows(mode_c);
    assign last_row = 2'(nrows - 3'h1);
    assign slots    = lcd_pkg::mode_slots(mode_c);
    assign step     = lcd_pkg::mode_step(mode_c);

    // ========================================
    // Input buffer.
    byte_stream_if #(.W(lcd_pkg::BYTE_W)) up_if ();
    byte_stream_if #(.W(lcd_pkg::BYTE_W)) dn_if ();

    logic accept;

    assign up_if.valid = byte_valid;
    assign up_if.data  = byte_data;
    assign byte_ready  = up_if.ready;
    // Commands take the cycle, so the buffer stalls behind them.
    assign dn_if.ready = !ptr_load_stb && !subaddr_load_stb;
    assign accept      = dn_if.valid && dn_if.ready;

    byte_skid_buf #(.W(lcd_pkg::BYTE_W), .DEPTH(2)) u_buf (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .up       (up_if),
        .dn       (dn_if)
    );

    // ========================================
    // Display clock selection.
    logic [CW-1:0] osc_r, osc_nxt;
    logic          pin_q_r, tick_r, tick_nxt;
    logic          clk_out_r, clk_out_nxt;

    // Internal divider or edges of the clock pin give one tick per display clock.
    always_comb begin
        osc_nxt     = '0;
        tick_nxt    = 1'b0;
        clk_out_nxt = 1'b0;
        if (!osc_sel) begin
            if (osc_r == CW'(OSC_TICK_CYC - 1)) begin
                tick_nxt = 1'b1; // RULE1
            end else begin
                osc_nxt = osc_r + 1'b1;
            end
            clk_out_nxt = (osc_r < CW'(OSC_TICK_CYC / 2)); // RULE1
        end else begin
            tick_nxt = clk_pin_in && !pin_q_r; // RULE2
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_r      <= '0;
            pin_q_r    <= 1'b0;
            tick_r     <= 1'b0;
            clk_out_r  <= 1'b0;
            clk_pin_oe <= 1'b0;
        end else if (clk_en) begin
            osc_r      <= osc_nxt;
            pin_q_r    <= clk_pin_in;
            tick_r     <= tick_nxt;
            clk_out_r  <= clk_out_nxt;
            clk_pin_oe <= !osc_sel; // RULE1 RULE2
        end
    end

    assign clk_pin_out = clk_out_r;

    // ========================================
    // Row scan, frame and sync.
    logic [1:0]      row_r, row_nxt;
    logic [SW-1:0]   slot_r, slot_nxt;
    logic            inv_r, inv_nxt, frame_nxt, load_disp, sync_jump;
    logic [COLS-1:0] disp_r, disp_nxt, row_bits;
    logic [3:0]      bp_nxt;

    // Each row lasts 24/n ticks, so n rows make one frame of 24 ticks.
    always_comb begin
        row_nxt   = row_r;
        slot_nxt  = slot_r;
        inv_nxt   = inv_r;
        frame_nxt = 1'b0;
        load_disp = 1'b0;
        sync_jump = 1'b0;
        if (tick_r) begin
            if (!sync_n_in && row_r != last_row) begin
                sync_jump = 1'b1; // RULE4
                row_nxt   = last_row; // RULE24
                slot_nxt  = '0;
                load_disp = 1'b1;
            end else if (slot_r >= slots - 1'b1) begin
                slot_nxt  = '0;
                load_disp = 1'b1;
                if (row_r >= last_row) begin
                    row_nxt   = 2'h0;
                    inv_nxt   = !inv_r;
                    frame_nxt = 1'b1; // RULE3
                end else begin
                    row_nxt = row_r + 2'h1;
                end
            end else begin
                slot_nxt = slot_r + 1'b1;
            end
        end
        disp_nxt = load_disp ? row_bits : disp_r; // RULE5
    end

    // Backplane n is active when row n is scanned, with copies per mode.
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            bp_nxt[r] = (row_r == 2'(r)) ^ inv_r; // RULE11
        end
        unique case (mode_c)
            lcd_pkg::MODE_STATIC: bp_nxt = {4{(row_r == 2'h0) ^ inv_r}}; // RULE9
            lcd_pkg::MODE_MUX2:   bp_nxt = {bp_nxt[1:0], bp_nxt[1:0]}; // RULE8
            lcd_pkg::MODE_MUX3:   bp_nxt[3] = bp_nxt[1]; // RULE7
            lcd_pkg::MODE_MUX4:   bp_nxt = bp_nxt;
        endcase
    end

    // Scan state and drive registers; the frame inversion keeps the cells free of DC.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            row_r               <= 2'h0;
            slot_r              <= '0;
            inv_r               <= 1'b0;
            disp_r              <= '0;
            frame_rate          <= 1'b0;
            sync_n_oe           <= 1'b0;
            sync_n_out          <= 1'b0;
            backplane_drive_out <= 4'h0;
            segment_drive_out   <= '0;
        end else if (clk_en) begin
            row_r               <= row_nxt;
            slot_r              <= slot_nxt;
            inv_r               <= inv_nxt;
            disp_r              <= disp_nxt;
            frame_rate          <= frame_nxt;
            sync_n_oe           <= (row_nxt == last_row); // RULE4
            backplane_drive_out <= bp_nxt;
            segment_drive_out   <= ~(disp_r ^ {COLS{inv_r}}); // RULE6 RULE10
        end
    end

    // ========================================
    // Data pointer and subaddress counter.
    logic [PW-1:0] ptr_r, ptr_nxt;
    logic [2:0]    sub_r, sub_nxt;
    logic [7:0]    sum;
    logic          wr_en;

    always_comb begin
        ptr_nxt = ptr_r;
        sub_nxt = sub_r;
        sum     = {1'b0, ptr_r} + step;
        wr_en   = accept && (sub_r == hw_subaddr_pins); // RULE17
        if (ptr_load_stb) begin
            ptr_nxt = ptr_load_val; // RULE14
        end
        if (subaddr_load_stb) begin
            sub_nxt = subaddr_load_val; // RULE19
        end
        if (accept) begin
            if (sum >= 8'(COLS)) begin
                ptr_nxt = PW'(sum - 8'(COLS)); // RULE25
                sub_nxt = sub_r + 3'h1; // RULE19
            end else begin
                ptr_nxt = sum[PW-1:0]; // RULE15 RULE18
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ptr_r <= lcd_pkg::PTR_RST; // RULE23
            sub_r <= lcd_pkg::SUB_RST; // RULE23
        end else if (clk_en) begin
            ptr_r <= ptr_nxt;
            sub_r <= sub_nxt;
        end
    end

    // ========================================
    // Display memory, one column per segment.
    logic [3:0] ram_r [COLS];

    for (genvar k = 0; k < COLS; k++) begin : g_col
        logic [3:0] col_nxt;
        int         off;
        int         idx;

        // Row r of column pointer+i takes byte bit 7-(n*i+r) while that bit exists.
        always_comb begin
            col_nxt = ram_r[k];
            off     = k - int'(ptr_r);
            idx     = 0;
            if (wr_en && off >= 0 && off < int'(step)) begin // RULE14
                for (int r = 0; r < 4; r++) begin
                    idx = 7 - (int'(nrows) * off + r);
                    if (r < int'(nrows) && idx >= 0) begin
                        col_nxt[r] = dn_if.data[idx[2:0]]; // RULE12 RULE13
                    end
                end
            end
        end

        assign row_bits[k] = ram_r[k][row_nxt]; // RULE11

        always_ff @(posedge core_clk) begin
            if (rst) begin
                ram_r[k] <= 4'h0;
            end else if (clk_en) begin
                ram_r[k] <= col_nxt;
            end
        end
    end

    // ========================================
    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    int unsigned tcnt_r;
    logic        tcnt_ok_r;

    // Ticks since the frame started, realigned by sync and voided by a mode change.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tcnt_r    <= 0;
            tcnt_ok_r <= 1'b0;
        end else if (clk_en) begin
            if (frame_nxt) begin
                tcnt_r    <= 0;
                tcnt_ok_r <= 1'b1;
            end else if (sync_jump) begin
                tcnt_r <= lcd_pkg::FRAME_DIV - int'(slots);
            end else if (tick_r) begin
                tcnt_r <= tcnt_r + 1;
            end
            if ($changed(drive_mode)) begin
                tcnt_ok_r <= 1'b0;
            end
        end
    end

    sequence s_take;
        clk_en && accept;
    endsequence

    a_frame_div: assert property (frame_nxt && tcnt_ok_r |-> tcnt_r == FRAME_LAST) // RULE3
        else $error("frame not after 24 display clocks");

    a_ptr_step: assert property (s_take |=> ptr_r == ((int'($past(ptr_r)) +
        int'($past(step))) % COLS)) // RULE15
        else $error("pointer did not advance by mode step");

    a_sub_carry: assert property (s_take ##0 (sum >= 8'(COLS)) && !subaddr_load_stb
        |=> sub_r == $past(sub_r) + 3'h1) // RULE19
        else $error("subaddress counter missed overflow");

    a_mismatch_drop: assert property (s_take ##0 (sub_r != hw_subaddr_pins)
        |-> !wr_en ##1 ptr_r != $past(ptr_r) || step == 8'(COLS)) // RULE18
        else $error("mismatch stored a byte or froze the pointer");

    a_bp_mux3: assert property (clk_en && mode_c == lcd_pkg::MODE_MUX3 ##1
        $stable(drive_mode) |-> backplane_drive_out[3] == backplane_drive_out[1]) // RULE7
        else $error("backplane 3 differs from 1");

    a_bp_mux2: assert property (clk_en && mode_c == lcd_pkg::MODE_MUX2 ##1
        $stable(drive_mode) |-> backplane_drive_out[3:2] == backplane_drive_out[1:0]) // RULE8
        else $error("backplane pairs differ");

    a_bp_static: assert property (clk_en && mode_c == lcd_pkg::MODE_STATIC ##1
        $stable(drive_mode) |-> backplane_drive_out inside {4'h0, 4'hF}) // RULE9
        else $error("static backplanes differ");

    a_sync_restart: assert property (clk_en && tick_r && !sync_n_in && row_r != last_row
        |=> row_r == $past(last_row) && slot_r == '0) // RULE24
        else $error("sync did not restart the scan");

    a_disp_hold: assert property (clk_en && !load_disp |=> $stable(disp_r)) // RULE5
        else $error("display register changed mid phase");

    a_clk_dir: assert property (clk_en |=> clk_pin_oe == !$past(osc_sel)) // RULE1
        else $error("clock pin direction wrong");

    a_reset_clear: assert property (disable iff (1'b0) rst |=> ptr_r == '0 && sub_r == '0) // RULE23
        else $error("reset left pointer or subaddress set");
endmodule

// file: verif/lcd_host_model.sv
// Host model that issues decoded commands and display bytes.
`timescale 1ns/1ps
module lcd_host_model (
    // Clock.
    input  wire logic  core_clk,
    // Decoded commands.
    output logic       ptr_load_stb,
    output logic [6:0] ptr_load_val,
    output logic       subaddr_load_stb,
    output logic [2:0] subaddr_load_val,
    // Display byte stream.
    input  wire logic  byte_ready,
    output logic       byte_valid,
    output logic [7:0] byte_data
);
    int unsigned n_acc;

    // All idle low.
    initial begin
        {ptr_load_stb, ptr_load_val, subaddr_load_stb, subaddr_load_val} = '0;
        {byte_valid, byte_data} = '0;
    end

    // One-cycle pointer (is_ptr) or subaddress load strobe.
    task automatic cmd(input bit is_ptr, input logic [6:0] v);
        @(negedge core_clk);
        ptr_load_stb     = is_ptr;
        ptr_load_val     = v;
        subaddr_load_stb = !is_ptr;
        subaddr_load_val = v[2:0];
        @(negedge core_clk);
        ptr_load_stb     = 1'h0;
        subaddr_load_stb = 1'h0;
    endtask

    // Holds the offered byte until taken; released data shows its inverse.
    task automatic drain();
        while (byte_ready !== 1'h1) @(negedge core_clk);
        @(negedge core_clk);
        byte_valid = 1'h0;
        byte_data  = ~byte_data;
    endtask

    // Offers one byte.
    task automatic send(input logic [7:0] b);
        @(negedge core_clk);
        byte_valid = 1'h1;
        byte_data  = b;
        drain();
    endtask

    // Stalls the core with a held pointer strobe and counts bytes taken.
    task automatic fill(input logic [6:0] v, input logic [7:0] b0);
        bit acc;
        @(negedge core_clk);
        ptr_load_stb = 1'h1;
        ptr_load_val = v;
        byte_valid   = 1'h1;
        byte_data    = b0;
        n_acc        = 0;
        repeat (4) begin
            acc = (byte_ready === 1'h1);
            @(negedge core_clk);
            if (acc) begin
                n_acc++;
                byte_data = byte_data + 8'h01;
            end
        end
        ptr_load_stb = 1'h0;
        drain();
    endtask
endmodule

// file: verif/lcd_segment_ram_and_mux_timing_tb.sv
// Self-checking bench for the segment LCD core.
`timescale 1ns/1ps
module lcd_segment_ram_and_mux_timing_tb;
    localparam int TICK = 8;
    logic                 core_clk, rst, osc_sel, clk_pin_in, clk_pin_out, clk_pin_oe;
    logic                 sync_n_out, sync_n_oe, tb_sync_n, ptr_load_stb, subaddr_load_stb;
    logic                 byte_valid, byte_ready, frame_rate;
    logic [2:0]           pins, subaddr_load_val, m_sub;
    logic [6:0]           ptr_load_val;
    logic [7:0]           byte_data;
    logic [3:0]           bp;
    logic [59:0]          seg;
    logic [59:0]          exp_r [4];
    lcd_pkg::drive_mode_t mode;
    int                   m_ptr = 0, failures = 0, n_tests = 0, cyc = 0;
    // Open-drain sync wire with pull-up.
    wire                  sync_wire = tb_sync_n & ~(sync_n_oe & ~sync_n_out);

    lcd_seg_core #(.OSC_TICK_CYC(TICK)) u_dut (
        .core_clk, .rst, .clk_en(1'h1), .osc_sel, .clk_pin_in, .clk_pin_out, .clk_pin_oe,
        .sync_n_in(sync_wire), .sync_n_out, .sync_n_oe, .drive_mode(mode),
        .hw_subaddr_pins(pins), .ptr_load_stb, .ptr_load_val, .subaddr_load_stb,
        .subaddr_load_val, .byte_valid, .byte_data, .byte_ready,
        .backplane_drive_out(bp), .segment_drive_out(seg), .frame_rate);

    lcd_host_model u_host (
        .core_clk, .ptr_load_stb, .ptr_load_val, .subaddr_load_stb, .subaddr_load_val,
        .byte_ready, .byte_valid, .byte_data);

    // ==========
    // Clock that never stops, external display clock and cycle ceiling.
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        if (osc_sel) clk_pin_in <= ~clk_pin_in;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    // ==========
    // Shared helpers.
    task automatic cmp(input string what, input logic [59:0] e, s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic set_mode(input lcd_pkg::drive_mode_t m);
        @(negedge core_clk);
        mode = m;
    endtask

    // Active row: the backplane that differs from the others.
    function automatic int act_row(input logic [3:0] b);
        act_row = -1;
        for (int i = 0; i < 4; i++)
            if (b[i] !== b[(i + 1) % 4] && b[i] !== b[(i + 2) % 4]) act_row = i;
    endfunction

    // Expected RAM update and pointer advance for one byte.
    task automatic model(input logic [7:0] b);
        int n;
        int st;
        int k;
        n = (mode == lcd_pkg::MODE_MUX4) ? 4 : int'(mode);
        st = (n == 3) ? 3 : 8 / n;
        for (int i = 0; i < st; i++) begin
            for (int r = 0; r < n; r++) begin
                k = 7 - (n * i + r);
                if (k >= 0 && m_sub == pins && m_ptr + i < 60) exp_r[r][m_ptr + i] = b[k];
            end
        end
        m_ptr += st;
        if (m_ptr >= 60) begin
            m_ptr -= 60;
            m_sub++;
        end
    endtask

    task automatic put(input logic [7:0] b);
        model(b);
        u_host.send(b);
    endtask

    // Rebuilds each row in 1:4 from segment and backplane levels.
    task automatic check_ram();
        set_mode(lcd_pkg::MODE_MUX4);
        repeat (4) @(negedge core_clk);
        while (act_row(bp) != 3) @(negedge core_clk);
        for (int r = 0; r < 4; r++) begin
            while (act_row(bp) != r) @(negedge core_clk);
            repeat (2) @(negedge core_clk);
            cmp("ram row", exp_r[r], seg ^ {60{bp[r]}});
        end
    endtask

    task automatic frame_gap(input int n);
        int c;
        for (int k = 0; k < 2; k++) begin
            c = 0;
            do begin
                @(negedge core_clk);
                c++;
            end while (frame_rate !== 1'h1);
        end
        cmp("frame period", 60'(n), 60'(c));
    endtask

    // ==========
    // Scenarios.
    task automatic t_write();
        put(8'hA5);
        u_host.cmd(1'h1, 7'h14);
        m_ptr = 20;
        repeat (3) put(8'hFF);
        set_mode(lcd_pkg::MODE_STATIC);
        u_host.cmd(1'h1, 7'h1E);
        m_ptr = 30;
        put(8'h3C);
        set_mode(lcd_pkg::MODE_MUX2);
        u_host.cmd(1'h1, 7'h28);
        m_ptr = 40;
        put(8'h96);
        put(8'h5A);
        set_mode(lcd_pkg::MODE_MUX3);
        u_host.cmd(1'h1, 7'h14);
        m_ptr = 20;
        put(8'h00);
        put(8'hB6);
        check_ram();
        $display("test write done");
    endtask

    task automatic t_sub();
        set_mode(lcd_pkg::MODE_MUX4);
        pins = 3'h1;
        u_host.cmd(1'h0, 7'h00);
        u_host.cmd(1'h1, 7'h3A);
        m_sub = 3'h0;
        m_ptr = 58;
        put(8'hC3);
        put(8'h7E);
        check_ram();
        $display("test subaddress done");
    endtask

    task automatic t_buf();
        m_ptr = 10;
        model(8'h11);
        model(8'h12);
        model(8'h13);
        u_host.fill(7'h0A, 8'h11);
        cmp("bytes taken while stalled", 60'h2, 60'(u_host.n_acc));
        check_ram();
        $display("test buffer done");
    endtask

    task automatic t_bp();
        int bad;
        for (int k = 0; k < 3; k++) begin
            set_mode(lcd_pkg::drive_mode_t'(k + 1));
            bad = 0;
            repeat (3) @(negedge core_clk);
            repeat (200) begin
                @(negedge core_clk);
                if (k == 0 && bp !== 4'h0 && bp !== 4'hF) bad++;
                if (k == 1 && bp[3:2] !== bp[1:0]) bad++;
                if (k == 2 && bp[3] !== bp[1]) bad++;
            end
            cmp("backplane copies", 60'h0, 60'(bad));
        end
        $display("test backplane done");
    endtask

    task automatic t_clk();
        int rises = 0;
        logic prev;
        set_mode(lcd_pkg::MODE_MUX4);
        repeat (2) @(negedge core_clk);
        cmp("clock pin enable", 60'h1, 60'(clk_pin_oe));
        repeat (80) begin
            prev = clk_pin_out;
            @(negedge core_clk);
            if (prev === 1'h0 && clk_pin_out === 1'h1) rises++;
        end
        cmp("clock pin rises", 60'hA, 60'(rises));
        frame_gap(24 * TICK);
        osc_sel = 1'h1;
        repeat (2) @(negedge core_clk);
        cmp("clock pin enable", 60'h0, 60'(clk_pin_oe));
        frame_gap(24 * 2);
        osc_sel = 1'h0;
        $display("test clock done");
    endtask

    task automatic t_sync();
        while (act_row(bp) != 1) @(negedge core_clk);
        tb_sync_n = 1'h0;
        repeat (TICK) @(negedge core_clk);
        tb_sync_n = 1'h1;
        repeat (2) @(negedge core_clk);
        cmp("row after sync", 60'h3, 60'(act_row(bp)));
        cmp("own sync pull", 60'h1, 60'(sync_n_oe));
        $display("test sync done");
    endtask

    // ==========
    // Main sequence.
    initial begin
        rst = 1'h1;
        osc_sel = 1'h0;
        clk_pin_in = 1'h0;
        tb_sync_n = 1'h1;
        pins = 3'h0;
        mode = lcd_pkg::MODE_MUX4;
        exp_r = '{default: '0};
        m_sub = 3'h0;
        repeat (5) @(negedge core_clk);
        cmp("ready in reset", 60'h0, 60'(byte_ready));
        rst = 1'h0;
        repeat (2) @(negedge core_clk);
        cmp("ready after reset", 60'h1, 60'(byte_ready));
        t_write();
        t_sub();
        t_buf();
        t_bp();
        t_clk();
        t_sync();
        stop_test();
    end
endmodule
